// ---- hw/seq_defs.svh ----
// seq_defs.svh: timing counts and rail count for the rail sequencer
// assumes a 10 MHz system clock
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define CLK_PERIOD_NS      100
`define SOFT_START_NS      1000000
`define SOFT_START_CYCLES  (`SOFT_START_NS / `CLK_PERIOD_NS)
`define PG_DEGLITCH_CYCLES 16
`define RAIL_COUNT         3
`endif

// ---- hw/seq_pkg.sv ----
// seq_pkg.sv: types shared by the rail sequencer files
// assumes seq_defs.svh supplies the numbers
package seq_pkg;
	typedef enum logic [1:0] {
		ORDER_123,
		ORDER_213,
		ORDER_231,
		ORDER_NONE
	} order_t;
endpackage : seq_pkg

// ---- hw/soft_start_timer.sv ----
// soft_start_timer.sv: fixed-interval ramp timer for one rail
// assumes run is from logic on sys_clk
`timescale 1ns/1ps
`include "seq_defs.svh"
module soft_start_timer #(
	parameter int CYCLES = `SOFT_START_CYCLES
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// control
	input  wire logic run,
	output logic      done
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// elaboration check: a zero count would report done before the rail ramps
	if (CYCLES < 1) begin : g_bad_cycles
		$error("soft start count must be at least one");
	end

	// count while run is high, clear when dropped so a restart retimes fully
	always_comb begin
		cnt_nxt = cnt_r;
		if (!run) begin
			cnt_nxt = '0;
		end else if (cnt_r != W'(CYCLES)) begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign done = (cnt_r == W'(CYCLES));
endmodule : soft_start_timer

// ---- hw/rail_sequencer.sv ----
// rail_sequencer.sv: start/stop sequencing and supply-ok for three buck rails
// assumes pin levels are digitized by comparators; they are synchronised here
`timescale 1ns/1ps
`include "seq_defs.svh"
module rail_sequencer
	import seq_pkg::*;
#(
	parameter int SS_CYCLES = `SOFT_START_CYCLES,
	parameter int PG_CYCLES = `PG_DEGLITCH_CYCLES
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// straps and enables (pull-ups make a floating pin read high)
	input  wire logic mode_strap,
	input  wire logic rail_one_enable,
	input  wire logic rail_two_enable,
	input  wire logic rail_three_enable,
	input  wire logic [2:0] enable_armed,
	// analog status
	input  wire logic input_low_lockout,
	input  wire logic over_temp,
	input  wire logic rail_one_ramp_low,
	input  wire logic [2:0] in_regulation,
	// outputs
	output logic [2:0] rail_run,
	output logic       internal_bias_regulator,
	output logic       supply_ok_flag_o,
	output logic       supply_ok_flag_oe
);
	import seq_pkg::*;

	typedef enum {ST_OFF, ST_UP, ST_ON, ST_DOWN} seq_state_t;

	localparam int PW = $clog2(PG_CYCLES + 1);

	// elaboration check: a zero deglitch would let supply-ok follow glitches
	if (PG_CYCLES < 1) begin : g_bad_deglitch
		$error("deglitch count must be at least one");
	end

	// two-flop synchronisers for every pin input
	logic [12:0] s1_r;
	logic [12:0] s2_r;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_r <= 13'h0000;
			s2_r <= 13'h0000;
		end else begin
			s1_r <= {mode_strap, rail_one_enable, rail_two_enable, rail_three_enable,
			         enable_armed, input_low_lockout, over_temp, rail_one_ramp_low,
			         in_regulation};
			s2_r <= s1_r;
		end
	end
	logic       mode_s, en1_s, en2_s, en3_s, input_low_lockout_s, ot_s, ramp1_low_s;
	logic [2:0] arm_s, reg_s;
	assign {mode_s, en1_s, en2_s, en3_s, arm_s, input_low_lockout_s, ot_s, ramp1_low_s, reg_s} = s2_r;

	// soft start timers for rails two and three share one module
	logic [2:0] run_r, run_nxt;
	logic [2:0] ss_done;
	assign ss_done[0] = !ramp1_low_s;
	genvar g;
	generate
		for (g = 1; g < 3; g++) begin : g_ss
			soft_start_timer #(.CYCLES(SS_CYCLES)) u_ss (
				.sys_clk (sys_clk),
				.rst     (rst),
				.run     (run_r[g]),
				.done    (ss_done[g])
			);
		end
	endgenerate

	// a rail counts as started when its ramp is over and it regulates
	logic [2:0] started;
	assign started = ss_done & reg_s;

	// order decode; both low leaves automatic mode off
	logic   auto_mode;
	order_t order;
	assign auto_mode = mode_s && (en1_s || en2_s);
	always_comb begin
		case ({en1_s, en2_s})
			2'b11:   order = ORDER_123;
			2'b01:   order = ORDER_213;
			2'b10:   order = ORDER_231;
			default: order = ORDER_NONE;
		endcase
	end

	// rail index at each step of the start order
	function automatic logic [1:0] step_rail(order_t o, logic [1:0] s);
		logic [1:0] r;
		r = 2'd0;
		case (o)
			ORDER_123: r = s;
			ORDER_213: r = (s == 2'd0) ? 2'd1 : (s == 2'd1) ? 2'd0 : 2'd2;
			ORDER_231: r = (s == 2'd0) ? 2'd1 : (s == 2'd1) ? 2'd2 : 2'd0;
			default:   r = 2'd0;
		endcase
		return r;
	endfunction : step_rail

	// sequencing state; order is latched at launch so a moving strap cannot reorder
	seq_state_t st_r, st_nxt;
	logic [1:0] step_r, step_nxt;
	order_t     ord_r, ord_nxt;
	logic       fault;
	logic [1:0] cur;
	assign fault = input_low_lockout_s || ot_s;
	assign cur   = step_rail(ord_r, step_r);

	always_comb begin
		st_nxt      = st_r;
		step_nxt    = step_r;
		ord_nxt     = ord_r;
		run_nxt     = run_r;
		if (fault) begin
			run_nxt  = 3'b000;
			st_nxt   = ST_OFF;
			step_nxt = 2'd0;
		end else if (!auto_mode) begin
			run_nxt     = {en3_s, en2_s, en1_s};
			st_nxt      = ST_OFF;
			step_nxt    = 2'd0;
		end else begin
			// once a fault clears, a still-high en3 relaunches from ST_OFF
			case (st_r)
				ST_OFF: begin
					run_nxt = 3'b000;
					if (en3_s && order != ORDER_NONE) begin
						ord_nxt  = order;
						step_nxt = 2'd0;
						st_nxt   = ST_UP;
					end
				end
				ST_UP: begin
					if (!en3_s) begin
						st_nxt = ST_DOWN;
						// a rail already commanded on must be the first to stop
						step_nxt = (run_r[cur] || step_r == 2'd0) ? step_r : step_r - 2'd1;
					end else if (!run_r[cur]) begin
						run_nxt[cur] = 1'b1;
					end else if (started[cur]) begin
						if (step_r == 2'd2) st_nxt = ST_ON;
						else step_nxt = step_r + 2'd1;
					end
				end
				ST_ON: begin
					if (!en3_s) begin
						st_nxt   = ST_DOWN;
						step_nxt = 2'd2;
					end
				end
				ST_DOWN: begin
					// reverse walk; next rail only after current one reads off
					if (run_r[cur]) begin
						run_nxt[cur] = 1'b0;
					end else if (!reg_s[cur]) begin
						if (step_r == 2'd0) st_nxt = ST_OFF;
						else step_nxt = step_r - 2'd1;
					end
				end
				default: st_nxt = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r      <= ST_OFF;
			step_r    <= 2'd0;
			ord_r     <= ORDER_NONE;
			run_r     <= 3'b000;
		end else begin
			st_r      <= st_nxt;
			step_r    <= step_nxt;
			ord_r     <= ord_nxt;
			run_r     <= run_nxt;
		end
	end

	// supply-ok deglitch; hold reasons force the counter back to zero
	logic [PW-1:0] pg_cnt_r, pg_cnt_nxt;
	logic          pg_nxt, bias_r, bias_nxt;
	logic          hold;
	assign hold = fault || !(en1_s && en2_s && en3_s) || (run_r & ~ss_done) != 3'b000
	           || (auto_mode && st_r != ST_ON);
	always_comb begin
		pg_cnt_nxt = pg_cnt_r;
		pg_nxt     = 1'b0;
		bias_nxt   = arm_s != 3'b000;
		if (hold || reg_s != 3'b111) begin
			pg_cnt_nxt = '0;
		end else if (pg_cnt_r != PW'(PG_CYCLES)) begin
			pg_cnt_nxt = pg_cnt_r + PW'(1);
		end else begin
			pg_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pg_cnt_r <= '0;
			bias_r   <= 1'b0;
		end else begin
			pg_cnt_r <= pg_cnt_nxt;
			bias_r   <= bias_nxt;
		end
	end

	// open drain: drive low unless good; the output value itself is constant low
	logic oe_r;
	always_ff @(posedge sys_clk) begin
		if (rst) oe_r <= 1'b1;
		else oe_r <= !pg_nxt;
	end

	assign rail_run                = run_r;
	assign internal_bias_regulator = bias_r;
	assign supply_ok_flag_o        = 1'b0;
	assign supply_ok_flag_oe       = oe_r;

	// assertions
	chk_lockout_off: assert property (@(posedge sys_clk) disable iff (rst)
		input_low_lockout_s |=> rail_run == 3'b000) else $error("rail runs during lockout");
	chk_indep_follow: assert property (@(posedge sys_clk) disable iff (rst)
		(!mode_s && !fault) |=> rail_run == $past({en3_s, en2_s, en1_s}))
		else $error("independent rail mismatch");
	chk_pg_needs_reg: assert property (@(posedge sys_clk) disable iff (rst)
		!oe_r |-> $past(reg_s, 2) == 3'b111) else $error("supply ok without regulation");
	chk_pg_hold_en: assert property (@(posedge sys_clk) disable iff (rst)
		!en3_s |=> oe_r) else $error("supply ok with enable low");
	chk_step_wait: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == ST_UP && run_r[cur] && !started[cur] && en3_s && !fault && auto_mode)
		|=> step_r == $past(step_r)) else $error("sequence advanced early");
	chk_stop_launch: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == ST_ON && !en3_s && !fault && auto_mode) |=> st_r == ST_DOWN)
		else $error("stop not launched");
	chk_bias_arm: assert property (@(posedge sys_clk) disable iff (rst)
		arm_s != 3'b000 |=> internal_bias_regulator) else $error("bias not on");
	chk_first_rail: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r == ST_UP && step_r == 2'd0 && ord_r == ORDER_123 && en3_s && !fault && auto_mode)
		|=> !rail_run[1] && !rail_run[2]) else $error("wrong first rail");
endmodule : rail_sequencer

// ---- test/rail_stage_model.sv ----
// rail_stage_model.sv: behavioural power stages and enable pins around the sequencer
// assumes rail_run is registered on sys_clk; enables are open-drain pulls with pull-ups
`timescale 1ns/1ps
module rail_stage_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// enable pins: controller only pulls low, pull-up gives high
	input  wire logic [2:0] en_pull_low,
	output logic      [2:0] rail_en,
	// power stage status
	input  wire logic [2:0] rail_run,
	output logic      [2:0] in_regulation,
	output logic            rail_one_ramp_low
);
	logic [2:0] run_d0_r;
	logic [2:0] run_d1_r;
	logic [2:0] run_d2_r;

	// a released pin floats high, so no push-pull drive is modelled
	assign rail_en = ~en_pull_low;

	// outputs need three cycles to ramp; losing run drops regulation at once
	always_ff @(posedge sys_clk) begin
		run_d0_r <= rst ? 3'h0 : rail_run;
		run_d1_r <= rst ? 3'h0 : run_d0_r;
		run_d2_r <= rst ? 3'h0 : run_d1_r;
	end
	assign in_regulation     = run_d2_r & rail_run;
	// ramp pin crosses the reference one cycle before regulation
	assign rail_one_ramp_low = rail_run[0] & ~run_d1_r[0];
endmodule : rail_stage_model

// ---- test/tb.sv ----
// tb.sv: self-checking bench for the rail sequencer
// assumes rail_stage_model stands at the far side; supply-ok pin has a pull-up
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
	logic       sys_clk           = 1'b0;
	logic       rst               = 1'b1;
	logic       mode_strap        = 1'b0;
	logic       input_low_lockout = 1'b0;
	logic       over_temp         = 1'b0;
	logic [2:0] en_pull_low       = 3'h7;
	logic [2:0] enable_armed      = 3'h0;
	logic [2:0] rail_en, in_regulation, rail_run, exp_v;
	logic       ramp_low, bias, pg_o, pg_oe, supply_ok_flag;
	int         errors = 0, cmp_count = 0, seed = 10920, k, i;
	logic [2:0] exp_q[$];
	logic [1:0] sel_t[3]   = '{2'h0, 2'h1, 2'h2};
	logic [2:0] start_t[3] = '{3'h1, 3'h2, 3'h2};
	logic [2:0] mid_t[3]   = '{3'h3, 3'h3, 3'h6};
	logic [2:0] stop_t[3]  = '{3'h1, 3'h2, 3'h2};

	// open-drain flag resolved against its pull-up
	assign supply_ok_flag = pg_oe ? pg_o : 1'b1;

	initial forever #50 sys_clk = ~sys_clk;

	rail_sequencer #(.SS_CYCLES(20), .PG_CYCLES(16)) rail_sequencer_inst (
		.sys_clk(sys_clk), .rst(rst), .mode_strap(mode_strap),
		.rail_one_enable(rail_en[0]), .rail_two_enable(rail_en[1]),
		.rail_three_enable(rail_en[2]), .enable_armed(enable_armed),
		.input_low_lockout(input_low_lockout), .over_temp(over_temp),
		.rail_one_ramp_low(ramp_low), .in_regulation(in_regulation),
		.rail_run(rail_run), .internal_bias_regulator(bias),
		.supply_ok_flag_o(pg_o), .supply_ok_flag_oe(pg_oe));

	rail_stage_model rail_stage_model_inst (
		.sys_clk(sys_clk), .rst(rst), .en_pull_low(en_pull_low), .rail_en(rail_en),
		.rail_run(rail_run), .in_regulation(in_regulation), .rail_one_ramp_low(ramp_low));

	task finish_test;
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// every change of the run commands must be the oldest noted step
	always @(rail_run) if (!rst) begin
		exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 3'hx;
		`CHK("rail_run", exp_v, rail_run)
	end

	task wait_run(input logic [2:0] v);
		for (int n = 0; n < 400 && rail_run !== v; n++) @(negedge sys_clk);
		if (rail_run !== v) begin
			errors++;
			$display("[ERR] wait rail_run exp %h got %h", v, rail_run);
			finish_test();
		end
	endtask : wait_run

	task step(input logic [2:0] pull, input logic [2:0] v);
		exp_q.push_back(v);
		en_pull_low = pull;
		wait_run(v);
	endtask : step

	initial begin
		#(100 * 90000);
		errors++;
		$display("[ERR] timeout");
		finish_test();
	end

	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK("bias", 1'b0, bias)
		enable_armed = 3'($random(seed)) | 3'h1;
		repeat (4) @(negedge sys_clk);
		`CHK("bias", 1'b1, bias)
		// independent control, then the reserved auto code
		step(3'h6, 3'h1);
		step(3'h2, 3'h5);
		step(3'h3, 3'h4);
		step(3'h7, 3'h0);
		mode_strap = 1'b1;
		step(3'h3, 3'h4);
		step(3'h7, 3'h0);
		for (k = 0; k < 3; k++) begin
			en_pull_low = {1'b1, sel_t[k]};
			repeat (6) @(negedge sys_clk);
			exp_q.push_back(start_t[k]);
			exp_q.push_back(mid_t[k]);
			step({1'b0, sel_t[k]}, 3'h7);
			repeat (20) @(negedge sys_clk);
			`CHK("supply_ok", 1'b0, supply_ok_flag)
			for (i = 0; i < 60 && supply_ok_flag !== (k == 0); i++) @(negedge sys_clk);
			`CHK("supply_ok", (k == 0), supply_ok_flag)
			exp_q.push_back(3'h0);
			if (k == 0) input_low_lockout = 1'b1;
			else over_temp = 1'b1;
			wait_run(3'h0);
			`CHK("supply_ok", 1'b0, supply_ok_flag)
			exp_q.push_back(start_t[k]);
			exp_q.push_back(mid_t[k]);
			exp_q.push_back(3'h7);
			input_low_lockout = 1'b0;
			over_temp = 1'b0;
			wait_run(3'h7);
			// last pass stops mid start; the others stop from the finished sequence
			if (k != 2) repeat (30) @(negedge sys_clk);
			exp_q.push_back(mid_t[k]);
			exp_q.push_back(stop_t[k]);
			step({1'b1, sel_t[k]}, 3'h0);
			en_pull_low = 3'h7;
			repeat (6) @(negedge sys_clk);
		end
		finish_test();
	end
endmodule : tb
